// ### logic/p1g_consts.vh
/*
 * Constants for the eight-bit I/O port with function multiplexer: register
 * indices, reset values, read-modify-write operation codes, bus answers.
 * Assumes inclusion by bare name from the port design files and the bench.
 */
// Notes on behaviour
// [R1] Direction bit one drives, zero receives.
// [R2] Plain data read returns sampled pin levels.
// [R3] Read-modify-write operations use stored latch value.
// [R4] Pin levels always readable, any direction.
// [R5] Pull-up on only when input and latch one.
// [R6] Function off: pin follows latch and direction.
// [R7] Open drain releases pin for high values.
// [R8] Output with function off drives latch bit.
// [R9] Pin 7: PWM high AND buzzer, XOR latch.
// [R10] Pin 6: PWM low XOR latch bit.
// [R11] Pin 5: second serial clock OR latch.
// [R12] Pins 4,3: second serial data OR latch.
// [R13] Pin 2: first serial clock OR latch.
// [R14] Pins 1,0: first serial data OR latch.
// [R15] Second serial input taken from pin 4.
// [R16] First serial input taken from pin 1.
// [R17] Per-bit build option: push-pull or open drain.
// [R18] Halt or hold freezes pins and registers.
// [R19] Reset clears latch, direction, function registers.
`ifndef P1G_CONSTS_VH
`define P1G_CONSTS_VH

// ********************************
// Register indices; byte address is four times the index.
// ********************************
`define P1G_IDX_LATCH     18'h0FE44
`define P1G_IDX_DIR       18'h0FE45
`define P1G_IDX_FUNC      18'h0FE46
`define P1G_IDX_LATCH_RB  18'h0FE47
`define P1G_IDX_RMW       18'h0FE48

// ********************************
// Decoded register selectors.
// ********************************
`define P1G_SEL_NONE      3'h0
`define P1G_SEL_LATCH     3'h1
`define P1G_SEL_DIR       3'h2
`define P1G_SEL_FUNC      3'h3
`define P1G_SEL_LATCH_RB  3'h4
`define P1G_SEL_RMW       3'h5

// ********************************
// Reset values and build options.
// ********************************
`define P1G_RST_BYTE      8'h00
`define P1G_OD_DEFAULT    8'h00

// ********************************
// Read-modify-write operation register fields and codes.
// ********************************
`define P1G_RMW_OP_HI     10
`define P1G_RMW_OP_LO     8
`define P1G_OP_SET        3'h1
`define P1G_OP_CLR        3'h2
`define P1G_OP_INV        3'h3
`define P1G_OP_INC        3'h4
`define P1G_OP_DEC        3'h5

// ********************************
// Bus answers.
// ********************************
`define P1G_RESP_OKAY     2'h0
`define P1G_RESP_SLVERR   2'h2
`define P1G_RDATA_ZERO    32'h0000_0000
`define P1G_PAD_ZERO      24'h00_0000

`endif

// ### logic/p1g_sync.v
/*
 * Two-stage synchroniser for the eight port pins.
 * Assumes the pins are asynchronous to mclk_i; only the second stage is
 * read by other logic.
 */
`include "p1g_consts.vh"
`default_nettype none

module p1g_sync (
    // Clock and reset.
    input  wire       mclk_i,
    input  wire       reset_n_i,
    // Raw and synchronised levels.
    input  wire [7:0] async_i,
    output wire [7:0] sync_o
);

    reg [7:0] meta_r;
    reg [7:0] sync_r;

    // The first stage feeds the second stage and nothing else.
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            meta_r <= `P1G_RST_BYTE;
            sync_r <= `P1G_RST_BYTE;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;

endmodule // p1g_sync

`default_nettype wire

// ### logic/p1g_port.v
/*
 * Eight-bit port with per-bit direction, latch-driven
 * pull-ups and a per-bit function mux merging PWM,
 * buzzer and two serial channels. Registers are reached
 * over an AXI4-Lite slave.
 * Assumes: peripheral sources and the halt/hold level run on mclk_i;
 * pins are asynchronous and pass p1g_sync; the pad ring turns
 * pin_out_o, pin_oe_o and pullup_en_o into a real wire.
 */
`include "p1g_consts.vh"
`default_nettype none

module p1g_port #(
    parameter [7:0] OPEN_DRAIN = `P1G_OD_DEFAULT
) (
    // Clock and reset.
    input  wire        mclk_i,
    input  wire        reset_n_i,
    // AXI4-Lite write address channel.
    input  wire [19:0] s_axi_awaddr_i,
    input  wire        s_axi_awvalid_i,
    output wire        s_axi_awready_o,
    // AXI4-Lite write data channel.
    input  wire [31:0] s_axi_wdata_i,
    input  wire [3:0]  s_axi_wstrb_i,
    input  wire        s_axi_wvalid_i,
    output wire        s_axi_wready_o,
    // AXI4-Lite write response channel.
    output wire [1:0]  s_axi_bresp_o,
    output wire        s_axi_bvalid_o,
    input  wire        s_axi_bready_i,
    // AXI4-Lite read address channel.
    input  wire [19:0] s_axi_araddr_i,
    input  wire        s_axi_arvalid_i,
    output wire        s_axi_arready_o,
    // AXI4-Lite read data channel.
    output wire [31:0] s_axi_rdata_o,
    output wire [1:0]  s_axi_rresp_o,
    output wire        s_axi_rvalid_o,
    input  wire        s_axi_rready_i,
    // Low-power state from the system controller.
    input  wire        halt_hold_i,
    // Peripheral function sources.
    input  wire        timer_high_side_pwm_i,
    input  wire        timer_low_side_pwm_i,
    input  wire        buzzer_signal_i,
    input  wire        first_serial_clk_i,
    input  wire        first_serial_data_i,
    input  wire        first_serial_active_i,
    input  wire        second_serial_clk_i,
    input  wire        second_serial_data_i,
    input  wire        second_serial_active_i,
    // Serial inputs returned to the serial channels.
    output wire        first_serial_in_o,
    output wire        second_serial_in_o,
    // Pins.
    input  wire [7:0]  pin_in_i,
    output wire [7:0]  pin_out_o,
    output wire [7:0]  pin_oe_o,
    output wire [7:0]  pullup_en_o
);

    // ****************************************************************
    // Address decode.
    // ****************************************************************

    // Maps a byte address to a register selector; used by both paths.
    function [2:0] p1g_decode;
        input [19:0] addr;
        begin
            case (addr[19:2])
                `P1G_IDX_LATCH:    p1g_decode = `P1G_SEL_LATCH;
                `P1G_IDX_DIR:      p1g_decode = `P1G_SEL_DIR;
                `P1G_IDX_FUNC:     p1g_decode = `P1G_SEL_FUNC;
                `P1G_IDX_LATCH_RB: p1g_decode = `P1G_SEL_LATCH_RB;
                `P1G_IDX_RMW:      p1g_decode = `P1G_SEL_RMW;
                default:           p1g_decode = `P1G_SEL_NONE;
            endcase
        end
    endfunction

    // ****************************************************************
    // Declarations.
    // ****************************************************************

    reg  [7:0]  port_output_latch_r;
    reg  [7:0]  port_direction_r;
    reg  [7:0]  port_function_select_r;
    reg  [7:0]  latch_nxt;
    reg  [7:0]  pin_smp_r;
    wire [7:0]  pin_sync;

    reg         awready_r;
    reg         wready_r;
    reg         aw_held_r;
    reg         w_held_r;
    reg  [19:0] awaddr_r;
    reg  [31:0] wdata_r;
    reg  [3:0]  wstrb_r;
    reg         bvalid_r;
    reg  [1:0]  bresp_r;
    reg         arready_r;
    reg         rvalid_r;
    reg  [1:0]  rresp_r;
    reg  [31:0] rdata_r;
    reg  [7:0]  rbyte;
    reg  [1:0]  rresp_nxt;

    wire [2:0]  wsel;
    wire [2:0]  rsel;
    wire        wr_fire;
    wire [2:0]  rmw_op;

    reg  [7:0]  fn_val;
    reg  [7:0]  pin_val;
    reg  [7:0]  pin_out_r;
    reg  [7:0]  pin_oe_r;
    reg  [7:0]  pullup_r;
    reg         first_in_r;
    reg         second_in_r;

    // ****************************************************************
    // Pin input path.
    // ****************************************************************

    p1g_sync u_sync (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .async_i   (pin_in_i),
        .sync_o    (pin_sync)
    );

    // Pin levels are sampled whatever the direction, so a driven pin
    // reads back its own level; the sample freezes in halt or hold.
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            pin_smp_r <= `P1G_RST_BYTE;
        end else if (!halt_hold_i) begin   // [R18]
            pin_smp_r <= pin_sync;         // [R4]
        end
    end

    // ****************************************************************
    // Write path.
    // ****************************************************************

    assign wsel    = p1g_decode(awaddr_r);
    assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
    assign rmw_op  = wdata_r[`P1G_RMW_OP_HI:`P1G_RMW_OP_LO];

    // Address and data come in either order and wait for each other;
    // readies stay low until the response is taken,
    // which keeps one write in flight.
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= 20'h0_0000;
            wdata_r   <= `P1G_RDATA_ZERO;
            wstrb_r   <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `P1G_RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && awready_r) begin
                awaddr_r  <= s_axi_awaddr_i;
                aw_held_r <= 1'b1;
                awready_r <= 1'b0;
            end
            if (s_axi_wvalid_i && wready_r) begin
                wdata_r  <= s_axi_wdata_i;
                wstrb_r  <= s_axi_wstrb_i;
                w_held_r <= 1'b1;
                wready_r <= 1'b0;
            end
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= (wsel == `P1G_SEL_NONE) ? `P1G_RESP_SLVERR : `P1G_RESP_OKAY;
            end
            if (bvalid_r && s_axi_bready_i) begin
                bvalid_r  <= 1'b0;
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
        end
    end

    // Next latch value. Operations work on the stored latch,
    // never the pins, so a pin pulled low by its load does
    // not corrupt neighbouring bits.
    always @* begin
        latch_nxt = port_output_latch_r;
        if (wsel == `P1G_SEL_LATCH && wstrb_r[0]) begin
            latch_nxt = wdata_r[7:0];
        end else if (wsel == `P1G_SEL_RMW && wstrb_r[0] && wstrb_r[1]) begin
            case (rmw_op)
                `P1G_OP_SET: latch_nxt = port_output_latch_r | wdata_r[7:0];     // [R3]
                `P1G_OP_CLR: latch_nxt = port_output_latch_r & ~wdata_r[7:0];    // [R3]
                `P1G_OP_INV: latch_nxt = port_output_latch_r ^ wdata_r[7:0];     // [R3]
                `P1G_OP_INC: latch_nxt = port_output_latch_r + 8'h01;            // [R3]
                `P1G_OP_DEC: latch_nxt = port_output_latch_r - 8'h01;            // [R3]
                default:     latch_nxt = port_output_latch_r;
            endcase
        end
    end

    // Register file. Writes are answered but discarded in halt or hold,
    // so the configuration at mode entry survives.
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            port_output_latch_r    <= `P1G_RST_BYTE;   // [R19]
            port_direction_r       <= `P1G_RST_BYTE;   // [R19]
            port_function_select_r <= `P1G_RST_BYTE;   // [R19]
        end else if (wr_fire && !halt_hold_i) begin    // [R18]
            port_output_latch_r <= latch_nxt;
            if (wsel == `P1G_SEL_DIR && wstrb_r[0]) begin
                port_direction_r <= wdata_r[7:0];
            end
            if (wsel == `P1G_SEL_FUNC && wstrb_r[0]) begin
                port_function_select_r <= wdata_r[7:0];
            end
        end
    end

    // ****************************************************************
    // Read path.
    // ****************************************************************

    assign rsel = p1g_decode(s_axi_araddr_i);

    // Read data selection; an unmapped address answers with an error and
    // zero data.
    always @* begin
        rbyte     = `P1G_RST_BYTE;
        rresp_nxt = `P1G_RESP_OKAY;
        case (rsel)
            `P1G_SEL_LATCH:    rbyte = pin_smp_r;              // [R2] [R4]
            `P1G_SEL_DIR:      rbyte = port_direction_r;
            `P1G_SEL_FUNC:     rbyte = port_function_select_r;
            `P1G_SEL_LATCH_RB: rbyte = port_output_latch_r;    // [R3]
            `P1G_SEL_RMW:      rbyte = `P1G_RST_BYTE;
            default:           rresp_nxt = `P1G_RESP_SLVERR;
        endcase
    end

    // One read in flight: the address is taken and the data registered on the
    // same edge, and they stand until rready.
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rresp_r   <= `P1G_RESP_OKAY;
            rdata_r   <= `P1G_RDATA_ZERO;
        end else begin
            if (s_axi_arvalid_i && arready_r) begin
                arready_r <= 1'b0;
                rvalid_r  <= 1'b1;
                rresp_r   <= rresp_nxt;
                rdata_r   <= {`P1G_PAD_ZERO, rbyte};
            end
            if (rvalid_r && s_axi_rready_i) begin
                rvalid_r  <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Function multiplexer and pin drive.
    // ****************************************************************

    // Function values merged with the latch per pin.
    always @* begin
        fn_val[7] = (timer_high_side_pwm_i & buzzer_signal_i)
                    ^ port_output_latch_r[7];                            // [R9]
        fn_val[6] = timer_low_side_pwm_i ^ port_output_latch_r[6];       // [R10]
        fn_val[5] = second_serial_clk_i | port_output_latch_r[5];        // [R11]
        fn_val[4] = second_serial_data_i | port_output_latch_r[4];       // [R12]
        fn_val[3] = second_serial_data_i | port_output_latch_r[3];       // [R12]
        fn_val[2] = first_serial_clk_i | port_output_latch_r[2];         // [R13]
        fn_val[1] = first_serial_data_i | port_output_latch_r[1];        // [R14]
        fn_val[0] = first_serial_data_i | port_output_latch_r[0];        // [R14]
        pin_val   = (port_function_select_r & fn_val)
                    | (~port_function_select_r & port_output_latch_r);   // [R8] [R6]
    end

    // Pin drive registers. An open-drain bit never drives high: a high
    // value simply drops the enable. The pads are frozen in halt or hold.
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            pin_out_r <= `P1G_RST_BYTE;
            pin_oe_r  <= `P1G_RST_BYTE;
            pullup_r  <= `P1G_RST_BYTE;
        end else if (!halt_hold_i) begin                                   // [R18]
            pin_out_r <= pin_val & ~OPEN_DRAIN;                            // [R17] [R7]
            pin_oe_r  <= port_direction_r & ~(OPEN_DRAIN & pin_val);       // [R1] [R6] [R7]
            pullup_r  <= ~port_direction_r & port_output_latch_r;          // [R5]
        end
    end

    // Serial inputs follow the pins in any direction, but
    // only while the channel runs; an idle one sees zero.
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            first_in_r  <= 1'b0;
            second_in_r <= 1'b0;
        end else begin
            first_in_r  <= first_serial_active_i & pin_smp_r[1];    // [R16]
            second_in_r <= second_serial_active_i & pin_smp_r[4];   // [R15]
        end
    end

    // ****************************************************************
    // Output assignments.
    // ****************************************************************

    assign s_axi_awready_o    = awready_r;
    assign s_axi_wready_o     = wready_r;
    assign s_axi_bresp_o      = bresp_r;
    assign s_axi_bvalid_o     = bvalid_r;
    assign s_axi_arready_o    = arready_r;
    assign s_axi_rdata_o      = rdata_r;
    assign s_axi_rresp_o      = rresp_r;
    assign s_axi_rvalid_o     = rvalid_r;
    assign first_serial_in_o  = first_in_r;
    assign second_serial_in_o = second_in_r;
    assign pin_out_o          = pin_out_r;
    assign pin_oe_o           = pin_oe_r;
    assign pullup_en_o        = pullup_r;

endmodule // p1g_port

`default_nettype wire

// ### dv/p1g_port_checker.sv
/* Concurrent checks on the port's pins and bus handshakes.
   Assumes binding into every p1g_port with OPEN_DRAIN handed on. */
`default_nettype none

module p1g_port_checker #(
    parameter logic [7:0] OPEN_DRAIN = 8'h00
) (
    // Clock and reset.
    input wire logic       mclk_i,
    input wire logic       reset_n_i,
    // Bus handshakes.
    input wire logic       s_axi_awvalid_i,
    input wire logic       s_axi_awready_o,
    input wire logic       s_axi_wvalid_i,
    input wire logic       s_axi_wready_o,
    input wire logic       s_axi_bvalid_o,
    input wire logic       s_axi_arvalid_i,
    input wire logic       s_axi_arready_o,
    input wire logic       s_axi_rvalid_o,
    // Mode and serial channels.
    input wire logic       halt_hold_i,
    input wire logic       first_serial_active_i,
    input wire logic       second_serial_active_i,
    input wire logic       first_serial_in_o,
    input wire logic       second_serial_in_o,
    // Pins.
    input wire logic [7:0] pin_in_i,
    input wire logic [7:0] pin_out_o,
    input wire logic [7:0] pin_oe_o,
    input wire logic [7:0] pullup_en_o
);
    // ********************************
    // Properties.
    // ********************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    // Reset check runs while reset is low.
    property p_rst;
        disable iff (1'b0) !reset_n_i |=> pin_oe_o == 8'h00 && pullup_en_o == 8'h00;
    endproperty
    a_rst: assert property (p_rst) else $error("pins active after reset");

    property p_pu;
        (pullup_en_o & pin_oe_o) == 8'h00;
    endproperty
    a_pu: assert property (p_pu) else $error("pull-up on a driven pin");

    property p_od;
        (pin_out_o & OPEN_DRAIN) == 8'h00;
    endproperty
    a_od: assert property (p_od) else $error("open drain pin driven high");

    property p_halt;
        $past(halt_hold_i) |-> $stable({pin_out_o, pin_oe_o, pullup_en_o});
    endproperty
    a_halt: assert property (p_halt) else $error("pins moved in halt");

    // Six cycles cover sync, sample and output flops.
    property p_s1on;
        (first_serial_active_i && !halt_hold_i && pin_in_i[1]) [*6] |=> first_serial_in_o;
    endproperty
    a_s1on: assert property (p_s1on) else $error("first serial input lost");

    property p_s2on;
        (second_serial_active_i && !halt_hold_i && pin_in_i[4]) [*6] |=> second_serial_in_o;
    endproperty
    a_s2on: assert property (p_s2on) else $error("second serial input lost");

    property p_s1off;
        !$past(first_serial_active_i) |-> !first_serial_in_o;
    endproperty
    a_s1off: assert property (p_s1off) else $error("idle serial input high");

    property p_wr;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
            |=> !s_axi_awready_o ##1 s_axi_bvalid_o;
    endproperty
    a_wr: assert property (p_wr) else $error("write answer late");

    property p_arr;
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o;
    endproperty
    a_arr: assert property (p_arr) else $error("read answer late");
endmodule // p1g_port_checker

`default_nettype wire

// ### dv/p1g_pin_model.sv
/* Outside circuitry on the eight pins: a driver the bench can enable per bit.
   Assumes the bench never drives a pin that the block drives. */
`default_nettype none

module p1g_pin_model (
    // Clock.
    input wire logic       mclk_i,
    // Block side.
    input wire logic [7:0] drv_out_i,
    input wire logic [7:0] drv_oe_i,
    input wire logic [7:0] pull_en_i,
    // Bench side.
    input wire logic [7:0] ext_en_i,
    input wire logic [7:0] ext_val_i,
    // Resolved wire levels.
    output var logic [7:0] lvl_o
);
    logic [7:0] last_r = 8'h00;

    // A floating pin toggles, so no stale level passes for a real one.
    always_ff @(posedge mclk_i) begin
        last_r <= lvl_o;
    end

    // Block drive first, then the outside driver, then the pull-up.
    assign lvl_o = (drv_oe_i & drv_out_i) | (~drv_oe_i & ((ext_en_i & ext_val_i)
                   | (~ext_en_i & (pull_en_i | ~last_r))));
endmodule // p1g_pin_model

`default_nettype wire

// ### dv/p1g_port_tb.sv
/* Self-checking bench: bus tasks, pin and mux checks.
   Assumes the block header is on the include path. */
`include "p1g_consts.vh"
`default_nettype none

module p1g_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0]  OD    = 8'hF0;
    localparam logic [19:0] A_LAT = {`P1G_IDX_LATCH, 2'b00}, A_DIR = {`P1G_IDX_DIR, 2'b00},
        A_FUN = {`P1G_IDX_FUNC, 2'b00}, A_RB = {`P1G_IDX_LATCH_RB, 2'b00},
        A_RMW = {`P1G_IDX_RMW, 2'b00}, A_BAD = 20'h00100;
    logic        mclk_i = 1'b0, reset_n_i = 1'b0, halt_hold_i = 1'b0;
    logic [19:0] s_axi_awaddr_i = 20'h00000, s_axi_araddr_i = 20'h00000;
    logic [31:0] s_axi_wdata_i = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb_i = 4'h0;
    logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
    logic        timer_high_side_pwm_i = 1'b0, timer_low_side_pwm_i = 1'b0;
    logic        buzzer_signal_i = 1'b0, first_serial_clk_i = 1'b0, first_serial_data_i = 1'b0;
    logic        second_serial_clk_i = 1'b0, second_serial_data_i = 1'b0;
    logic        first_serial_active_i = 1'b0, second_serial_active_i = 1'b0;
    logic [7:0]  ext_en = 8'h00, ext_val = 8'h00;
    wire  [1:0]  s_axi_bresp_o, s_axi_rresp_o;
    wire         s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
    wire         s_axi_rvalid_o, first_serial_in_o, second_serial_in_o;
    wire  [31:0] s_axi_rdata_o;
    wire  [7:0]  pin_in_i, pin_out_o, pin_oe_o, pullup_en_o, od_out, od_oe;
    logic [1:0]  rsp;
    logic [7:0]  v;
    int          err_total = 0, cmp_count = 0;
    logic [7:0]  lt [3] = '{8'h00, 8'hFF, 8'h5A};
    logic [7:0]  ft [3] = '{8'hFF, 8'hFF, 8'hA5};
    logic [2:0]  op_t [6] = '{`P1G_OP_SET, `P1G_OP_CLR, `P1G_OP_INV, `P1G_OP_INC,
                             `P1G_OP_DEC, `P1G_OP_DEC};
    logic [7:0]  mk_t [6] = '{8'h0F, 8'hF0, 8'hFF, 8'h00, 8'h00, 8'h00};
    logic [7:0]  ex_t [6] = '{8'hFF, 8'h0F, 8'hF0, 8'hF1, 8'hF0, 8'hEF};

    // ********************************
    // Clock, block instances and the outside circuitry.
    // ********************************
    always #20 mclk_i = ~mclk_i;

    p1g_port #(.OPEN_DRAIN(8'h00)) DUT (.*);
    // Open drain copy: same stimulus, only its drive pins compared.
    p1g_port #(.OPEN_DRAIN(OD)) DUT_OD (.*, .pin_out_o(od_out), .pin_oe_o(od_oe),
        .pullup_en_o(), .s_axi_awready_o(), .s_axi_wready_o(), .s_axi_bresp_o(),
        .s_axi_bvalid_o(), .s_axi_arready_o(), .s_axi_rdata_o(), .s_axi_rresp_o(),
        .s_axi_rvalid_o(), .first_serial_in_o(), .second_serial_in_o());
    p1g_pin_model u_pins (.mclk_i, .drv_out_i(pin_out_o), .drv_oe_i(pin_oe_o),
        .pull_en_i(pullup_en_o), .ext_en_i(ext_en), .ext_val_i(ext_val), .lvl_o(pin_in_i));

    // ********************************
    // Bus tasks and comparison.
    // ********************************
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // The answer ready is up from the start; each valid drops once taken.
    task automatic wr(logic [19:0] a, logic [31:0] d, logic [3:0] s = 4'h1);
        @(posedge mclk_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_wstrb_i <= s;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
        end while (s_axi_bvalid_o !== 1'b1);
        rsp = s_axi_bresp_o;
        s_axi_bready_i <= 1'b0;
    endtask

    task automatic rchk(string nm, logic [19:0] a, logic [31:0] e);
        @(posedge mclk_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
        end while (s_axi_rvalid_o !== 1'b1);
        rsp = s_axi_rresp_o;
        s_axi_rready_i <= 1'b0;
        chk(nm, s_axi_rdata_o, e);
    endtask

    // Pin value expected from latch, function select and the seven sources.
    function automatic logic [7:0] fexp(logic [7:0] l, logic [7:0] f, logic [6:0] k);
        logic [7:0] fn;
        fn = {(k[0] & k[1]) ^ l[7], k[2] ^ l[6], k[5] | l[5], {2{k[6]}} | l[4:3],
              k[3] | l[2], {2{k[4]}} | l[1:0]};
        return (f & fn) | (~f & l);
    endfunction

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // The whole sequence needs under 1000 cycles; some thirty times that means a hang.
    initial begin
        repeat (30000) @(posedge mclk_i);
        err_total++;
        end_of_test();
    end

    // ********************************
    // Main sequence.
    // ********************************
    initial begin
        repeat (16) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        rchk("dir", A_DIR, 32'h0);
        rchk("fun", A_FUN, 32'h0);
        rchk("latch", A_RB, 32'h0);
        rchk("bad", A_BAD, 32'h0);
        chk("bad_rd", rsp, `P1G_RESP_SLVERR);
        wr(A_BAD, 32'h0000_00FF);
        chk("bad_wr", rsp, `P1G_RESP_SLVERR);
        wr(A_DIR, 32'h0F);
        wr(A_LAT, 32'hF0);
        repeat (6) @(posedge mclk_i);
        chk("pullup", pullup_en_o, 32'hF0);
        chk("oe", pin_oe_o, 32'h0F);
        rchk("pins", A_LAT, 32'hF0);
        ext_val <= 8'h3C;
        ext_en <= 8'hF0;
        repeat (6) @(posedge mclk_i);
        rchk("pins", A_LAT, 32'h30);
        rchk("latch", A_RB, 32'hF0);
        for (int i = 0; i < 6; i++) begin
            wr(A_RMW, {21'h0, op_t[i], mk_t[i]}, 4'h3);
            rchk("rmw", A_RB, ex_t[i]);
        end
        ext_en <= 8'h00;
        wr(A_DIR, 32'hFF);
        for (int j = 0; j < 3; j++) begin
            wr(A_LAT, lt[j]);
            wr(A_FUN, ft[j]);
            for (int k = 0; k < 128; k++) begin
                {second_serial_data_i, second_serial_clk_i, first_serial_data_i,
                 first_serial_clk_i, timer_low_side_pwm_i, buzzer_signal_i,
                 timer_high_side_pwm_i} <= k[6:0];
                repeat (2) @(posedge mclk_i);
                v = fexp(lt[j], ft[j], k[6:0]);
                chk("out", pin_out_o, v);
                chk("od_out", od_out, v & ~OD);
                chk("od_oe", od_oe, {24'h0, ~(OD & v)});
            end
        end
        first_serial_active_i <= 1'b1;
        second_serial_active_i <= 1'b1;
        wr(A_FUN, 32'h0);
        wr(A_LAT, 32'h0);
        repeat (6) @(posedge mclk_i);
        chk("ser", {first_serial_in_o, second_serial_in_o}, 32'h0);
        wr(A_DIR, 32'h0);
        ext_val <= 8'hFF;
        ext_en <= 8'hFF;
        repeat (8) @(posedge mclk_i);
        chk("ser", {first_serial_in_o, second_serial_in_o}, 32'h3);
        first_serial_active_i <= 1'b0;
        second_serial_active_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        chk("ser", {first_serial_in_o, second_serial_in_o}, 32'h0);
        ext_en <= 8'h00;
        wr(A_DIR, 32'hFF);
        wr(A_LAT, 32'h55);
        halt_hold_i <= 1'b1;
        wr(A_LAT, 32'hAA);
        rchk("halt", A_RB, 32'h55);
        chk("halt_pin", pin_out_o, 32'h55);
        halt_hold_i <= 1'b0;
        wr(A_LAT, 32'hAA);
        rchk("latch", A_RB, 32'hAA);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        rchk("latch", A_RB, 32'h0);
        chk("oe", pin_oe_o, 32'h0);
        end_of_test();
    end
endmodule // p1g_port_tb

bind p1g_port p1g_port_checker #(.OPEN_DRAIN(OPEN_DRAIN)) u_chk (.*);

`default_nettype wire
